// ---- core/gpc_pkg.sv ----
// Purpose: Shared constants for the gated pulse counter with compare.
// Assumes: Avalon-MM byte addresses, one aligned 32-bit word per register.
// Notes: Field positions refer to bits within the register word.
package gpc_pkg;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_HIGH_LIMIT = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_LOAD_VALUE = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_COMPARE = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_DOUT = 5'h1c;
	// Control word fields.
	localparam int CTRL_SOFT_GATE = 0;
	localparam int CTRL_LOAD = 1;
	localparam int CTRL_RUN = 2;
	localparam int CTRL_LINK = 3;
	localparam int CTRL_W = 4;
	// Configuration word fields.
	localparam int CFG_EDGE_LO = 0;
	localparam int CFG_REACT = 2;
	localparam int CFG_OSET_LO = 4;
	localparam int CFG_HWG_EN = 6;
	localparam int CFG_DQ_ROUTE = 7;
	localparam int CFG_IRQ_EN = 8;
	localparam int CFG_W = 9;
	// Status word fields.
	localparam int STS_RANGE = 0;
	localparam int STS_INT_GATE = 1;
	localparam int STS_LIMIT_STOP = 2;
	localparam int STS_W = 3;
	// Edge selection codes.
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Output-setting codes.
	localparam logic [1:0] OSET_ABOVE = 2'h1;
	localparam logic [1:0] OSET_AT_OR_BELOW = 2'h2;
	// Limit reaction codes.
	localparam logic REACT_STOP = 1'b0;
	localparam logic REACT_CONTINUE = 1'b1;
	// Reset values.
	localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
	localparam logic [CFG_W-1:0] RST_CONFIG = 9'h011;
	localparam logic [CNT_W-1:0] RST_HIGH_LIMIT = 32'hffffffff;
	localparam logic [CNT_W-1:0] RST_LOAD_VALUE = 32'h00000000;
	localparam logic [CNT_W-1:0] RST_COMPARE = 32'h00000001;
	localparam logic [CNT_W-1:0] RST_COUNT = 32'h00000000;
	localparam int SYNC_STAGES = 2;
endpackage : gpc_pkg

// ---- core/gpc_edge_if.sv ----
// Purpose: Carries a synchronised pin level and its edge pulses.
// Assumes: All signals are on clk_sys.
// Notes: Rise and fall are one-cycle pulses from flip-flops.
`timescale 1ns/1ps
interface gpc_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : gpc_edge_if

// ---- core/gpc_edge_detect.sv ----
// Purpose: Synchronises one input pin and detects its edges.
// Assumes: The pin is asynchronous to clk_sys.
// Notes: Level and edges lag the pin by three clk_sys cycles, one more than the synchroniser depth.
`timescale 1ns/1ps
module gpc_edge_detect (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pin,
	gpc_edge_if.src edge_out
);
	logic sync_a;
	logic sync_b;
	logic held;
	logic rise;
	logic fall;
	logic next_rise;
	logic next_fall;

	always_comb begin
		next_rise = sync_b & ~held;
		next_fall = ~sync_b & held;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			held <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			held <= sync_b;
			rise <= next_rise;
			fall <= next_fall;
		end
	end

	assign edge_out.level = held;
	assign edge_out.rise = rise;
	assign edge_out.fall = fall;
endmodule : gpc_edge_detect

// ---- core/gpc_counter.sv ----
// Purpose: Gated 32-bit pulse up counter with limit and compare flag.
// Assumes: Avalon-MM slave on clk_sys; pins are asynchronous.
// Notes: Every access answers with waitrequest low one cycle after it rises.
`timescale 1ns/1ps
module gpc_counter #(
	parameter int CNT_W = gpc_pkg::CNT_W
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [gpc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic pulse_in,
	input wire logic hardware_gate_input_in,
	output logic di_level,
	output logic dq_out,
	output logic range_irq
);
	gpc_edge_if pulse_edge ();
	gpc_edge_if gate_edge ();

	gpc_edge_detect u_pulse (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin(pulse_in),
		.edge_out(pulse_edge)
	);

	gpc_edge_detect u_gate (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin(hardware_gate_input_in),
		.edge_out(gate_edge)
	);

	// Merges write data into a word under the Avalon byte enables.
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// Range flag for a count, comparison value and output setting.
	function automatic logic range_of(
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] cmp,
		input logic [1:0] oset
	);
		logic r;
		r = 1'b0;
		case (oset)
			gpc_pkg::OSET_ABOVE: begin
				r = (cnt > cmp);
			end
			gpc_pkg::OSET_AT_OR_BELOW: begin
				r = (cnt <= cmp);
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction : range_of

	// Bus-side register state.
	logic ack;
	logic [31:0] rdata;
	logic [gpc_pkg::CTRL_W-1:0] ctrl;
	logic [gpc_pkg::CFG_W-1:0] config_w;
	logic [CNT_W-1:0] high_limit;
	logic [CNT_W-1:0] load_value;
	logic [CNT_W-1:0] compare;
	logic dout;
	logic next_ack;
	logic [31:0] next_rdata;
	logic [gpc_pkg::CTRL_W-1:0] next_ctrl;
	logic [gpc_pkg::CFG_W-1:0] next_config_w;
	logic [CNT_W-1:0] next_high_limit;
	logic [CNT_W-1:0] next_load_value;
	logic [CNT_W-1:0] next_compare;
	logic next_dout;

	// Counter-side state.
	logic [CNT_W-1:0] count;
	logic limit_stop;
	logic range_flag;
	logic irq;
	logic load_prev;
	logic run_prev;
	logic link_prev;
	logic [CNT_W-1:0] next_count;
	logic next_limit_stop;
	logic next_range_flag;
	logic next_irq;

	// Decoded control and configuration fields.
	logic software_gate_bit;
	logic load_bit;
	logic run_bit;
	logic link_bit;
	logic [1:0] edge_sel;
	logic react;
	logic [1:0] oset;
	logic hwg_en;
	logic dq_route;
	logic irq_en;
	logic hardware_gate_input;
	logic gate_open;
	logic active;
	logic pulse_hit;
	logic exceed;
	logic [31:0] status_word;
	logic access;
	logic [31:0] ctrl_merged;
	logic [31:0] cfg_merged;

	assign software_gate_bit = ctrl[gpc_pkg::CTRL_SOFT_GATE];
	assign load_bit = ctrl[gpc_pkg::CTRL_LOAD];
	assign run_bit = ctrl[gpc_pkg::CTRL_RUN];
	assign link_bit = ctrl[gpc_pkg::CTRL_LINK];
	assign edge_sel = config_w[gpc_pkg::CFG_EDGE_LO +: 2];
	assign react = config_w[gpc_pkg::CFG_REACT];
	assign oset = config_w[gpc_pkg::CFG_OSET_LO +: 2];
	assign hwg_en = config_w[gpc_pkg::CFG_HWG_EN];
	assign dq_route = config_w[gpc_pkg::CFG_DQ_ROUTE];
	assign irq_en = config_w[gpc_pkg::CFG_IRQ_EN];

	// A disabled hardware gate reads as permanently open.
	assign hardware_gate_input = hwg_en ? gate_edge.level : 1'b1;
	// An automatic stop at the limit closes the internal gate.
	assign gate_open = software_gate_bit & hardware_gate_input & ~limit_stop;
	assign active = run_bit & link_bit;

	always_comb begin
		case (edge_sel)
			gpc_pkg::EDGE_RISE: begin
				pulse_hit = pulse_edge.rise;
			end
			gpc_pkg::EDGE_FALL: begin
				pulse_hit = pulse_edge.fall;
			end
			gpc_pkg::EDGE_BOTH: begin
				pulse_hit = pulse_edge.rise | pulse_edge.fall;
			end
			default: begin
				pulse_hit = 1'b0;
			end
		endcase
	end

	// The low end of the range is fixed at zero; only the top is a register.
	assign exceed = (count >= high_limit);

	always_comb begin
		status_word = 32'h00000000;
		status_word[gpc_pkg::STS_RANGE] = range_flag;
		status_word[gpc_pkg::STS_INT_GATE] = gate_open;
		status_word[gpc_pkg::STS_LIMIT_STOP] = limit_stop;
	end

	assign access = avs_read | avs_write;
	assign ctrl_merged = be_merge({28'h0000000, ctrl}, avs_writedata, avs_byteenable);
	assign cfg_merged = be_merge({23'h000000, config_w}, avs_writedata, avs_byteenable);

	always_comb begin
		next_ack = access & ~ack;
		next_rdata = rdata;
		next_ctrl = ctrl;
		next_config_w = config_w;
		next_high_limit = high_limit;
		next_load_value = load_value;
		next_compare = compare;
		next_dout = dout;
		if (avs_read && !ack) begin
			case (avs_address)
				gpc_pkg::OFS_CTRL: begin
					next_rdata = {28'h0000000, ctrl};
				end
				gpc_pkg::OFS_CONFIG: begin
					next_rdata = {23'h000000, config_w};
				end
				gpc_pkg::OFS_HIGH_LIMIT: begin
					next_rdata = high_limit;
				end
				gpc_pkg::OFS_LOAD_VALUE: begin
					next_rdata = load_value;
				end
				gpc_pkg::OFS_COMPARE: begin
					next_rdata = compare;
				end
				gpc_pkg::OFS_COUNT: begin
					next_rdata = count;
				end
				gpc_pkg::OFS_STATUS: begin
					next_rdata = status_word;
				end
				gpc_pkg::OFS_DOUT: begin
					next_rdata = {31'h00000000, dout};
				end
				default: begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
		if (avs_write && !ack) begin
			case (avs_address)
				gpc_pkg::OFS_CTRL: begin
					next_ctrl = ctrl_merged[gpc_pkg::CTRL_W-1:0];
				end
				gpc_pkg::OFS_CONFIG: begin
					next_config_w = cfg_merged[gpc_pkg::CFG_W-1:0];
				end
				gpc_pkg::OFS_HIGH_LIMIT: begin
					next_high_limit = be_merge(high_limit, avs_writedata,
						avs_byteenable);
				end
				gpc_pkg::OFS_LOAD_VALUE: begin
					next_load_value = be_merge(load_value, avs_writedata,
						avs_byteenable);
				end
				gpc_pkg::OFS_COMPARE: begin
					next_compare = be_merge(compare, avs_writedata,
						avs_byteenable);
				end
				gpc_pkg::OFS_DOUT: begin
					if (avs_byteenable[0]) begin
						next_dout = avs_writedata[0];
					end
				end
				default: begin
					next_dout = dout;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			rdata <= 32'h00000000;
			ctrl <= gpc_pkg::RST_CTRL;
			config_w <= gpc_pkg::RST_CONFIG;
			high_limit <= gpc_pkg::RST_HIGH_LIMIT;
			load_value <= gpc_pkg::RST_LOAD_VALUE;
			compare <= gpc_pkg::RST_COMPARE;
			dout <= 1'b0;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
			ctrl <= next_ctrl;
			config_w <= next_config_w;
			high_limit <= next_high_limit;
			load_value <= next_load_value;
			compare <= next_compare;
			dout <= next_dout;
		end
	end

	assign avs_waitrequest = access & ~ack;
	assign avs_readdata = rdata;

	always_comb begin
		next_count = count;
		next_limit_stop = limit_stop;
		// Closing either gate re-arms counting after an automatic stop.
		if (limit_stop && (!software_gate_bit || (hwg_en && !gate_edge.level))) begin
			next_limit_stop = 1'b0;
		end
		if ((run_bit && !run_prev) || (link_bit && !link_prev)) begin
			next_count = gpc_pkg::RST_COUNT;
		end else if (load_bit && !load_prev) begin
			next_count = load_value;
		end else if (active && gate_open && pulse_hit) begin
			if (exceed) begin
				next_count = gpc_pkg::RST_COUNT;
				if (react == gpc_pkg::REACT_STOP) begin
					next_limit_stop = 1'b1;
				end
			end else begin
				next_count = count + 1'b1;
			end
		end
		next_range_flag = range_of(count, compare, oset);
		next_irq = irq_en & next_range_flag & ~range_flag;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count <= gpc_pkg::RST_COUNT;
			limit_stop <= 1'b0;
			range_flag <= 1'b0;
			irq <= 1'b0;
			load_prev <= 1'b0;
			run_prev <= 1'b0;
			link_prev <= 1'b0;
		end else begin
			count <= next_count;
			limit_stop <= next_limit_stop;
			range_flag <= next_range_flag;
			irq <= next_irq;
			load_prev <= load_bit;
			run_prev <= run_bit;
			link_prev <= link_bit;
		end
	end

	assign di_level = pulse_edge.level;
	// When routed, software writes to the output word no longer reach the pin.
	assign dq_out = dq_route ? range_flag : dout;
	assign range_irq = irq;
endmodule : gpc_counter

// ---- dv/gpc_counter_chk.sv ----
// Purpose: Concurrent checks on the counter's bus and pin ports.
// Assumes: One clock domain, rst_b asynchronous and active low.
// Notes: Bound to every gpc_counter instance.
`timescale 1ns/1ps
module gpc_counter_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [gpc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic pulse_in,
	input wire logic di_level,
	input wire logic range_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high while idle");
	chk_read_ack: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not answered after one cycle");
	chk_write_ack: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("write not answered after one cycle");
	chk_irq_single: assert property (range_irq |=> !range_irq)
		else $error("interrupt longer than one cycle");
	chk_di_follow: assert property ($past(rst_b, 3) |-> di_level == $past(pulse_in, 3))
		else $error("input image does not follow the pin");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_status_width: assert property (avs_read && !avs_waitrequest
		&& avs_address == gpc_pkg::OFS_STATUS |-> avs_readdata[31:3] == 29'h0)
		else $error("status upper bits set");
	chk_ctrl_width: assert property (avs_read && !avs_waitrequest
		&& avs_address == gpc_pkg::OFS_CTRL |-> avs_readdata[31:4] == 28'h0)
		else $error("control upper bits set");
endmodule : gpc_counter_chk

bind gpc_counter gpc_counter_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pulse_in(pulse_in),
	.di_level(di_level), .range_irq(range_irq));

// ---- dv/gpc_pulse_src.sv ----
// Purpose: Field-side pulse source that feeds the counter pin.
// Assumes: Each level lasts three clocks, so every edge is seen.
// Notes: A burst starts low, goes high n times and ends low.
`timescale 1ns/1ps
module gpc_pulse_src (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic go,
	input wire logic [7:0] n,
	output logic pulse_in,
	output logic busy
);
	logic [7:0] left;
	logic [1:0] ph;
	assign busy = left != 8'h0;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			left <= 8'h0;
			ph <= 2'h0;
			pulse_in <= 1'h0;
		end else if (go && left == 8'h0) begin
			left <= n;
			ph <= 2'h0;
		end else if (left != 8'h0) begin
			ph <= ph + 2'h1;
			if (ph == 2'h2) begin
				pulse_in <= !pulse_in;
				ph <= 2'h0;
				if (pulse_in)
					left <= left - 8'h1;
			end
		end
	end
endmodule : gpc_pulse_src

// ---- dv/test_gated_pulse_counter_compare.sv ----
// Purpose: Self-checking bench for the gated pulse counter.
// Assumes: Reads are answered one cycle after the request.
// Notes: Expected read data wait in a queue for the watcher.
`timescale 1ns/1ps
module test_gated_pulse_counter_compare;
	localparam logic [4:0] A_CTL = gpc_pkg::OFS_CTRL;
	localparam logic [4:0] A_CFG = gpc_pkg::OFS_CONFIG;
	localparam logic [4:0] A_HI = gpc_pkg::OFS_HIGH_LIMIT;
	localparam logic [4:0] A_CMP = gpc_pkg::OFS_COMPARE;
	localparam logic [4:0] A_CNT = gpc_pkg::OFS_COUNT;
	localparam logic [4:0] A_STS = gpc_pkg::OFS_STATUS;
	localparam logic [4:0] A_OUT = gpc_pkg::OFS_DOUT;
	logic clk_sys = 1'h0;
	logic rst_b = 1'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic pulse_go = 1'h0;
	logic hardware_gate_input_in = 1'h0;
	logic [4:0] avs_address = 5'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, c, v, i0;
	logic [31:0] seed = 32'h13143;
	logic [7:0] pulse_n = 8'h0;
	logic [7:0] k;
	logic avs_waitrequest, pulse_in, pulse_busy, di_level, dq_out, range_irq;
	int n_errors = 0;
	int checks_done = 0;
	int n_irq = 0;
	int cyc = 0;
	logic [31:0] q[$];
	always #2.5 clk_sys = ~clk_sys;
	gpc_counter dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pulse_in(pulse_in), .hardware_gate_input_in(hardware_gate_input_in), .di_level(di_level), .dq_out(dq_out),
		.range_irq(range_irq));
	gpc_pulse_src src (.clk_sys(clk_sys), .rst_b(rst_b), .go(pulse_go), .n(pulse_n),
		.pulse_in(pulse_in), .busy(pulse_busy));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	always @(posedge clk_sys) begin
		cyc++;
		if (range_irq === 1'h1)
			n_irq++;
		if (avs_read === 1'h1 && avs_waitrequest === 1'h0)
			chk("readdata", q.pop_front(), avs_readdata);
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Holds the request until waitrequest is sampled low, then idles one edge.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge clk_sys);
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'h0, a, 32'h0);
	endtask : rd
	task automatic ld(input logic [31:0] d, input logic [31:0] ctl);
		wr(gpc_pkg::OFS_LOAD_VALUE, d);
		wr(A_CTL, ctl | 32'h2);
		wr(A_CTL, ctl);
	endtask : ld
	task automatic pulses(input logic [7:0] n);
		pulse_n <= n;
		pulse_go <= 1'h1;
		@(posedge clk_sys);
		pulse_go <= 1'h0;
		@(posedge clk_sys);
		while (pulse_busy) @(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
	endtask : pulses
	task automatic chkdq(input logic e);
		repeat (3) @(posedge clk_sys);
		chk("dq_out", {31'h0, e}, {31'h0, dq_out});
	endtask : chkdq
	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'h1;
		@(posedge clk_sys);
		rd(A_CTL, 32'h0);
		rd(A_CFG, 32'h11);
		rd(A_HI, 32'hffffffff);
		rd(A_CMP, 32'h1);
		rd(A_STS, 32'h0);
		rd(5'h02, 32'h0);
		wr(A_CNT, 32'h5);
		rd(A_CNT, 32'h0);
		note("reset");
		wr(A_CTL, 32'hd);
		for (int e = 0; e < 4; e++) begin
			wr(A_CFG, 32'h10 | e);
			ld(32'h0, 32'hd);
			pulses(8'h3);
			rd(A_CNT, e == 0 ? 32'h0 : e == 3 ? 32'h6 : 32'h3);
		end
		note("edges");
		wr(A_CFG, 32'h11);
		ld(32'h0, 32'hc);
		pulses(8'h2);
		rd(A_CNT, 32'h0);
		wr(A_CTL, 32'hd);
		rd(A_STS, 32'h2);
		wr(A_CFG, 32'h51);
		rd(A_STS, 32'h0);
		pulses(8'h2);
		rd(A_CNT, 32'h0);
		hardware_gate_input_in <= 1'h1;
		k = rnd() % 4 + 1;
		pulses(k);
		rd(A_CNT, {24'h0, k});
		rd(A_STS, {30'h0, 1'h1, k > 8'h1});
		note("gate");
		v = rnd();
		ld(v, 32'hc);
		rd(A_CNT, v);
		note("load");
		c = rnd() >> 1;
		wr(A_CMP, c);
		wr(A_CFG, 32'h191);
		ld(c, 32'hd);
		i0 = n_irq;
		rd(A_STS, 32'h2);
		pulses(8'h1);
		rd(A_CNT, c + 32'h1);
		rd(A_STS, 32'h3);
		chk("irq", i0 + 1, n_irq);
		wr(A_OUT, 32'h0);
		chkdq(1'h1);
		wr(A_CFG, 32'h1a1);
		rd(A_STS, 32'h2);
		ld(c, 32'hd);
		rd(A_STS, 32'h3);
		chk("irq", i0 + 2, n_irq);
		wr(A_CFG, 32'h0a1);
		ld(c + 32'h1, 32'hd);
		ld(c, 32'hd);
		rd(A_STS, 32'h3);
		chk("irq", i0 + 2, n_irq);
		wr(A_CFG, 32'h21);
		chkdq(1'h0);
		wr(A_OUT, 32'h1);
		chkdq(1'h1);
		note("compare");
		wr(A_CMP, 32'h1);
		wr(A_HI, 32'h5);
		wr(A_CFG, 32'h11);
		ld(32'h5, 32'hd);
		pulses(8'h1);
		rd(A_STS, 32'h4);
		pulses(8'h2);
		rd(A_CNT, 32'h0);
		wr(A_CTL, 32'hc);
		wr(A_CTL, 32'hd);
		pulses(8'h2);
		rd(A_CNT, 32'h2);
		wr(A_CFG, 32'h15);
		ld(32'h5, 32'hd);
		pulses(8'h2);
		rd(A_CNT, 32'h1);
		rd(A_STS, 32'h2);
		note("limit");
		ld(32'h3, 32'hd);
		wr(A_CTL, 32'h9);
		pulses(8'h2);
		rd(A_CNT, 32'h3);
		wr(A_CTL, 32'hd);
		rd(A_CNT, 32'h0);
		ld(32'h3, 32'hd);
		wr(A_CTL, 32'h5);
		pulses(8'h2);
		rd(A_CNT, 32'h3);
		wr(A_CTL, 32'hd);
		rd(A_CNT, 32'h0);
		ld(32'h3, 32'hd);
		rd(A_CNT, 32'h3);
		rst_b <= 1'h0;
		@(posedge clk_sys);
		rst_b <= 1'h1;
		@(posedge clk_sys);
		rd(A_CNT, 32'h0);
		note("run");
		tally_and_finish();
	end
endmodule : test_gated_pulse_counter_compare
